//--- ddcs_top.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module ddcs_top (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [13:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire ddcs_pkg::ddcs_pins_t select_pins,
    output ddcs_pkg::ddcs_stages_t    stage_enable,
    output logic      [5:0]           decimation_ratio,
    output logic                      decimation_valid,
    output logic                      real_output,
    output logic                      quadrature_valid,
    output logic                      freq_shift_enable,
    output logic                      i_from_channel_b,
    output logic                      q_from_channel_b,
    output logic      [3:0]           nco_channel
);
    import ddcs_pkg::*;

    typedef struct packed {
        logic [7:0]   ctl;
        logic [7:0]   insel;
        logic [7:0]   ncoctl;
        logic [31:0]  rdata;
        logic         ready;
        logic         err;
        logic         real_out;
        logic         q_valid;
        logic         shift_en;
        logic         i_b;
        logic         q_b;
        logic [3:0]   chan;
    } ddcs_top_state_t;

    ddcs_top_state_t s_q;
    ddcs_top_state_t s_d;

    ddcs_chain_t chain;
    logic [3:0]  edge_count;
    logic        edge_mode;
    logic        edge_pin;
    logic [3:0]  mode;

    //////////////////////////////////////////////////////////////////////////
    // Decimation chain decoder, registered inside
    ddcs_chain_decode u_decode (
        .clk      (pclk),
        .rst_n    (presetn),
        .dec_code (s_q.ctl[2:0]),
        .ext_code (s_q.insel[7:4]),
        .c2r      (s_q.ctl[DDCS_CTL_C2R_BIT]),
        .chain    (chain)
    );

    //////////////////////////////////////////////////////////////////////////
    // Edge-counting channel selection
    assign mode      = s_q.ncoctl[7:4];
    assign edge_mode = (mode >= DDCS_MODE_EDGE_A0) && (mode <= DDCS_MODE_EDGE_B1);

    // Pin per mode: A0, A1, B0, B1
    always_comb begin
        unique case (mode[1:0])
            2'h0: edge_pin = select_pins.a0;
            2'h1: edge_pin = select_pins.a1;
            2'h2: edge_pin = select_pins.b0;
            2'h3: edge_pin = select_pins.b1;
        endcase
    end

    ddcs_chan_counter u_counter (
        .clk     (pclk),
        .rst_n   (presetn),
        .enable  (edge_mode),
        .pin     (edge_pin),
        .wrap_at (s_q.ncoctl[3:0]),
        .count   (edge_count)
    );

    //////////////////////////////////////////////////////////////////////////
    // APB slave, configuration and derived outputs
    always_comb begin
        logic        acc;
        logic [13:0] a;
        logic        hit;
        logic [7:0]  rd;
        acc = psel && penable && !s_q.ready;
        a   = paddr;
        hit = 1'b1;
        rd  = 8'h00;
        s_d = s_q;
        s_d.ready = acc;
        s_d.err   = 1'b0;

        // Read data and decode; one wait state per access
        unique case (a)
            DDCS_ADDR_CONTROL: rd = s_q.ctl;
            DDCS_ADDR_INSEL:   rd = s_q.insel & DDCS_INSEL_WMASK;
            DDCS_ADDR_NCOCTL:  rd = s_q.ncoctl;
            DDCS_ADDR_STATUS:  rd = {chain.valid, 3'h0, s_q.chan};
            default:           hit = 1'b0;
        endcase

        if (acc) begin
            s_d.err   = !hit;
            s_d.rdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd};
        end

        // Write lands on the completing edge, when the master samples pready
        if (psel && penable && s_q.ready && pwrite && pstrb[0]) begin
            unique case (a)
                DDCS_ADDR_CONTROL: s_d.ctl    = pwdata[7:0];
                DDCS_ADDR_INSEL:   s_d.insel  = pwdata[7:0] & DDCS_INSEL_WMASK;
                DDCS_ADDR_NCOCTL:  s_d.ncoctl = pwdata[7:0];
                default:           s_d.ctl    = s_q.ctl; // Status or unmapped: no write
            endcase
        end

        // Output form: real drops Q and enables extra shift
        s_d.real_out = s_q.ctl[DDCS_CTL_C2R_BIT];
        s_d.shift_en = s_q.ctl[DDCS_CTL_C2R_BIT];
        s_d.q_valid  = !s_q.ctl[DDCS_CTL_C2R_BIT];

        // Input routing, 0 is channel A
        s_d.i_b = s_q.insel[DDCS_INS_I_BIT];
        s_d.q_b = s_q.insel[DDCS_INS_Q_BIT];

        // Channel source by mode; unlisted modes fall back to register field
        if (mode == DDCS_MODE_PINS0) begin
            s_d.chan = {2'b00, select_pins.b0, select_pins.a0};
        end else if (mode == DDCS_MODE_PINS1) begin
            s_d.chan = {2'b00, select_pins.b1, select_pins.a1};
        end else if (edge_mode) begin
            s_d.chan = edge_count;
        end else begin
            s_d.chan = s_q.ncoctl[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q        <= '0;
            s_q.ctl    <= DDCS_RST_CONTROL;
            s_q.insel  <= DDCS_RST_INSEL;
            s_q.ncoctl <= DDCS_RST_NCOCTL;
            s_q.q_valid <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata            = s_q.rdata;
    assign pready            = s_q.ready;
    assign pslverr           = s_q.err;
    assign stage_enable      = chain.stages;
    assign decimation_ratio  = chain.ratio;
    assign decimation_valid  = chain.valid;
    assign real_output       = s_q.real_out;
    assign quadrature_valid  = s_q.q_valid;
    assign freq_shift_enable = s_q.shift_en;
    assign i_from_channel_b  = s_q.i_b;
    assign q_from_channel_b  = s_q.q_b;
    assign nco_channel       = s_q.chan;
endmodule
`default_nettype wire

//--- ddcs_pkg.sv
package ddcs_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [11:0] DDCS_IDX_CONTROL   = 12'h310;
    localparam logic [11:0] DDCS_IDX_INSEL     = 12'h311;
    localparam logic [11:0] DDCS_IDX_NCOCTL    = 12'h314;
    localparam logic [13:0] DDCS_ADDR_CONTROL  = 14'(DDCS_IDX_CONTROL * 4);
    localparam logic [13:0] DDCS_ADDR_INSEL    = 14'(DDCS_IDX_INSEL * 4);
    localparam logic [13:0] DDCS_ADDR_NCOCTL   = 14'(DDCS_IDX_NCOCTL * 4);
    localparam logic [13:0] DDCS_ADDR_STATUS   = 14'h0CA0;

    // Reset values
    localparam logic [7:0] DDCS_RST_CONTROL = 8'h00;
    localparam logic [7:0] DDCS_RST_INSEL   = 8'h00;
    localparam logic [7:0] DDCS_RST_NCOCTL  = 8'h00;

    // Field positions
    localparam int DDCS_CTL_C2R_BIT   = 3;
    localparam int DDCS_INS_I_BIT     = 0;
    localparam int DDCS_INS_Q_BIT     = 2;
    localparam logic [7:0] DDCS_INSEL_WMASK = 8'hF5;

    // Decimation field codes
    localparam logic [2:0] DDCS_DEC_EXT = 3'h7;

    // Channel select modes
    localparam logic [3:0] DDCS_MODE_REG    = 4'h0;
    localparam logic [3:0] DDCS_MODE_PINS0  = 4'h1;
    localparam logic [3:0] DDCS_MODE_PINS1  = 4'h2;
    localparam logic [3:0] DDCS_MODE_EDGE_A0 = 4'h8;
    localparam logic [3:0] DDCS_MODE_EDGE_B1 = 4'hB;

    // Stage enable bundle
    typedef struct packed {
        logic hb1;
        logic hb2;
        logic hb3;
        logic hb4;
        logic tb1;
        logic tb2;
        logic fb2;
    } ddcs_stages_t;

    // Decoded chain: stages, ratio, legality
    typedef struct packed {
        ddcs_stages_t stages;
        logic [5:0]   ratio;
        logic         valid;
    } ddcs_chain_t;

    // Four select pins
    typedef struct packed {
        logic b1;
        logic b0;
        logic a1;
        logic a0;
    } ddcs_pins_t;

endpackage

//--- ddcs_chain_decode.sv
`timescale 1ns/1ps
`default_nettype none
module ddcs_chain_decode
    import ddcs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [2:0]  dec_code,
    input  wire logic [3:0]  ext_code,
    input  wire logic        c2r,
    output ddcs_pkg::ddcs_chain_t chain
);
    typedef struct packed {
        ddcs_chain_t chain;
    } ddcs_dec_state_t;

    ddcs_dec_state_t s_q;
    ddcs_dec_state_t s_d;

    // Table of stage chains; complex ratio halved for real output except on TB1 chains
    always_comb begin
        ddcs_stages_t st;
        logic [5:0]   cplx;
        logic         half_ok;
        st      = '0;
        cplx    = 6'h00;
        half_ok = 1'b1;
        s_d     = s_q;
        unique case (dec_code)
            3'h0: begin st.hb1 = 1'b1; st.hb2 = 1'b1; cplx = 6'h04; end
            3'h1: begin st.hb1 = 1'b1; st.hb2 = 1'b1; st.hb3 = 1'b1; cplx = 6'h08; end
            3'h2: begin st.hb1 = 1'b1; st.hb2 = 1'b1; st.hb3 = 1'b1; st.hb4 = 1'b1;
                cplx = 6'h10;
            end
            3'h3: begin st.hb1 = 1'b1; cplx = 6'h02; end
            3'h4: begin st.hb1 = 1'b1; st.tb2 = 1'b1; cplx = 6'h06; end
            3'h5: begin st.hb1 = 1'b1; st.hb2 = 1'b1; st.tb2 = 1'b1; cplx = 6'h0C; end
            3'h6: begin st.hb1 = 1'b1; st.hb2 = 1'b1; st.hb3 = 1'b1; st.tb2 = 1'b1;
                cplx = 6'h18;
            end
            3'h7: begin
                // Upper nibble only counts here
                unique case (ext_code)
                    4'h0: begin st.hb1 = 1'b1; st.hb2 = 1'b1; st.hb3 = 1'b1;
                        st.hb4 = 1'b1; st.tb2 = 1'b1; cplx = 6'h30;
                    end
                    4'h2: begin st.fb2 = 1'b1; st.hb1 = 1'b1; cplx = 6'h0A; end
                    4'h3: begin st.fb2 = 1'b1; st.hb1 = 1'b1; st.hb2 = 1'b1;
                        cplx = 6'h14;
                    end
                    4'h4: begin st.fb2 = 1'b1; st.hb1 = 1'b1; st.hb2 = 1'b1;
                        st.hb3 = 1'b1; cplx = 6'h28;
                    end
                    4'h7: begin st.tb1 = 1'b1; cplx = 6'h03; half_ok = 1'b0; end
                    4'h8: begin st.tb1 = 1'b1; st.fb2 = 1'b1; cplx = 6'h0F;
                        half_ok = 1'b0;
                    end
                    4'h9: begin st.tb1 = 1'b1; st.fb2 = 1'b1; st.hb2 = 1'b1;
                        cplx = 6'h1E; half_ok = 1'b0;
                    end
                    default: begin st = '0; cplx = 6'h00; end
                endcase
            end
        endcase
        s_d.chain.stages = st;
        s_d.chain.valid  = (cplx != 6'h00) && !(c2r && !half_ok);
        // Real output halves the ratio where the chain allows it
        s_d.chain.ratio  = (c2r && half_ok) ? {1'b0, cplx[5:1]} : cplx;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign chain = s_q.chain;
endmodule
`default_nettype wire

//--- ddcs_chan_counter.sv
`timescale 1ns/1ps
`default_nettype none
module ddcs_chan_counter
    import ddcs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic       pin,
    input  wire logic [3:0] wrap_at,
    output logic      [3:0] count
);
    typedef struct packed {
        logic       pin_prev;
        logic [3:0] cnt;
    } ddcs_cnt_state_t;

    ddcs_cnt_state_t s_q;
    ddcs_cnt_state_t s_d;

    // Rising edge steps the counter, wrapping after the limit
    always_comb begin
        s_d          = s_q;
        s_d.pin_prev = pin;
        if (!enable) begin
            s_d.cnt = 4'h0;
        end else if (pin && !s_q.pin_prev) begin
            s_d.cnt = (s_q.cnt >= wrap_at) ? 4'h0 : s_q.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count = s_q.cnt;
endmodule
`default_nettype wire

//--- ddcs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ddcs_checker
    import ddcs_pkg::*;
(
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire ddcs_pkg::ddcs_pins_t   select_pins,
    input wire ddcs_pkg::ddcs_stages_t stage_enable,
    input wire logic [5:0]             decimation_ratio,
    input wire logic                   decimation_valid,
    input wire logic                   real_output,
    input wire logic                   quadrature_valid,
    input wire logic                   freq_shift_enable,
    input wire logic                   i_from_channel_b,
    input wire logic [3:0]             nco_channel
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] quiet_q;
    //////////////////////////////////////////////////////////////////////////
    // Cycles since last write or pin change; outputs lag their sources
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            quiet_q <= 3'h0;
        else if ((pready && pwrite) || !$stable(select_pins))
            quiet_q <= 3'h0;
        else if (quiet_q != 3'h7)
            quiet_q <= quiet_q + 3'h1;
    end
    // Product of the enabled stage factors
    function automatic int chain_ratio(ddcs_stages_t s);
        int n;
        n = s.hb1 + s.hb2 + s.hb3 + s.hb4;
        return (1 << n) * (s.tb1 ? 3 : 1) * (s.tb2 ? 3 : 1) * (s.fb2 ? 5 : 1);
    endfunction
    //////////////////////////////////////////////////////////////////////////
    pready_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside pready");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    real_quad_a: assert property (real_output != quadrature_valid)
        else $error("quadrature valid with real output");
    shift_follow_a: assert property (freq_shift_enable == real_output)
        else $error("frequency shift not tied to real output");
    chain_ratio_a: assert property (
        quiet_q >= 3'h6 && decimation_valid |->
        chain_ratio(stage_enable) == (real_output ? 2 : 1) * int'(decimation_ratio))
        else $error("ratio does not match stage chain");
    stage_hold_a: assert property (quiet_q >= 3'h6 |-> $stable(stage_enable))
        else $error("stages changed without a write");
    nco_hold_a: assert property (quiet_q >= 3'h6 |-> $stable(nco_channel))
        else $error("channel changed without a cause");
    route_change_a: assert property ($changed(i_from_channel_b) |->
        $past(pready && pwrite) || $past(pready && pwrite, 2))
        else $error("input route changed without a write");
    cover property (pslverr);
    cover property (real_output && decimation_valid);
    cover property (nco_channel == 4'h0 && $past(nco_channel) == 4'h2);
endmodule
`default_nettype wire

//--- ddcs_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module ddcs_top_test;
    import ddcs_pkg::*;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic         decimation_valid, real_output, quadrature_valid, freq_shift_enable;
    logic         i_from_channel_b, q_from_channel_b;
    logic [13:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [3:0]   pstrb, nco_channel;
    logic [5:0]   decimation_ratio;
    ddcs_pins_t   select_pins;
    ddcs_stages_t stage_enable;
    int           fail_count, tests_run;
    // Expected chain per entry: seven plain codes, then seven extended ones
    localparam logic [6:0] STG [14] = '{7'h60, 7'h70, 7'h78, 7'h40, 7'h42, 7'h62, 7'h72,
        7'h7A, 7'h41, 7'h61, 7'h71, 7'h04, 7'h05, 7'h25};
    localparam logic [5:0] CPX [14] = '{6'd4, 6'd8, 6'd16, 6'd2, 6'd6, 6'd12, 6'd24,
        6'd48, 6'd10, 6'd20, 6'd40, 6'd3, 6'd15, 6'd30};
    // Plain codes carry a nonzero nibble that must be ignored
    localparam logic [3:0] EXT [14] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3,
        4'h0, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9};
    localparam logic [13:0] REGS [3] = '{DDCS_ADDR_CONTROL, DDCS_ADDR_INSEL, DDCS_ADDR_NCOCTL};
    ddcs_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .select_pins, .stage_enable, .decimation_ratio, .decimation_valid,
        .real_output, .quadrature_valid, .freq_shift_enable, .i_from_channel_b,
        .q_from_channel_b, .nco_channel);
    //////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds the request until pready is sampled high, no fixed latency assumed
    task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Outputs trail their sources by at most two edges; sample well clear of the edge
    task automatic settle;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask
    // Pin levels change just after a rising edge, like every other input
    task automatic set_pins(input logic [3:0] v);
        @(posedge pclk);
        select_pins <= ddcs_pins_t'(v);
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        settle;
        chk({stage_enable, decimation_ratio}, {7'h60, 6'd4});
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, REGS[i], 32'h0);
            chk(rd, 32'h0);
        end
        pstrb <= 4'h0;
        apb(1'b1, DDCS_ADDR_CONTROL, 32'h8);
        pstrb <= 4'hF;
        apb(1'b0, DDCS_ADDR_CONTROL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 14'h0C48, 32'hFF);
        chk(err, 1'b1);
        $display("reset and access test done");
    endtask
    task automatic test_decim;
        logic [2:0] d;
        for (int i = 0; i < 14; i++) begin
            for (int c = 0; c < 2; c++) begin
                d = (i < 7) ? 3'(i) : DDCS_DEC_EXT;
                apb(1'b1, DDCS_ADDR_INSEL, {24'h0, EXT[i], 4'h0});
                apb(1'b1, DDCS_ADDR_CONTROL, {28'h0, c[0], d});
                settle;
                chk(stage_enable, STG[i]);
                chk({real_output, quadrature_valid, freq_shift_enable},
                    c ? 3'h5 : 3'h2);
                if (c == 1 && i > 10)
                    chk(decimation_valid, 1'b0);
                else
                    chk({decimation_valid, decimation_ratio},
                        {1'b1, c ? CPX[i] >> 1 : CPX[i]});
            end
        end
        $display("decimation test done");
    endtask
    task automatic test_insel;
        apb(1'b1, DDCS_ADDR_INSEL, 32'hFF);
        apb(1'b0, DDCS_ADDR_INSEL, 32'h0);
        chk(rd, 32'hF5);
        chk(err, 1'b0);
        settle;
        chk({i_from_channel_b, q_from_channel_b}, 2'b11);
        apb(1'b1, DDCS_ADDR_INSEL, 32'h04);
        settle;
        chk({i_from_channel_b, q_from_channel_b}, 2'b01);
        $display("input select test done");
    endtask
    task automatic test_nco;
        apb(1'b1, DDCS_ADDR_NCOCTL, 32'h0A);
        settle;
        chk(nco_channel, 4'hA);
        // Status: chain valid (ext 0, real) and the register channel
        apb(1'b0, DDCS_ADDR_STATUS, 32'h0);
        chk(rd, 32'h8A);
        set_pins(4'b0110);
        apb(1'b1, DDCS_ADDR_NCOCTL, 32'h1F);
        settle;
        chk(nco_channel, 4'h2);
        apb(1'b1, DDCS_ADDR_NCOCTL, 32'h2F);
        settle;
        chk(nco_channel, 4'h1);
        // Each edge mode: other pins must not count, wrap after two
        for (int m = 0; m < 4; m++) begin
            set_pins(4'h0);
            apb(1'b1, DDCS_ADDR_NCOCTL, 32'h02);
            apb(1'b1, DDCS_ADDR_NCOCTL, {24'h0, 4'h8 + 4'(m), 4'h2});
            set_pins(~(4'h1 << m));
            settle;
            set_pins(4'h0);
            settle;
            chk(nco_channel, 4'h0);
            for (int k = 1; k < 5; k++) begin
                set_pins(4'h1 << m);
                settle;
                set_pins(4'h0);
                settle;
                chk(nco_channel, 4'(k % 3));
            end
        end
        $display("channel select test done");
    endtask
    // Reset in mid-run must restore registers and outputs
    task automatic test_midreset;
        apb(1'b1, DDCS_ADDR_INSEL, 32'h05);
        settle;
        @(posedge pclk);
        presetn <= 1'b0;
        settle;
        chk({real_output, quadrature_valid, i_from_channel_b, nco_channel}, 7'h20);
        @(posedge pclk);
        presetn <= 1'b1;
        settle;
        chk({stage_enable, decimation_ratio}, {7'h60, 6'd4});
        apb(1'b0, DDCS_ADDR_INSEL, 32'h0);
        chk(rd, 32'h0);
        $display("mid-run reset test done");
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        select_pins = ddcs_pins_t'(4'h0);
        fail_count = 0;
        tests_run = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        test_reset;
        test_decim;
        test_insel;
        test_nco;
        test_midreset;
        complete_run;
    end
    // Whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        complete_run;
    end
endmodule
bind ddcs_top ddcs_checker u_checker (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
    .pready, .pslverr, .select_pins, .stage_enable, .decimation_ratio, .decimation_valid,
    .real_output, .quadrature_valid, .freq_shift_enable, .i_from_channel_b, .nco_channel);
`default_nettype wire
